// ### twm_cfg.svh
// Offsets, field positions, reset values and timing counts of the two-wire master receiver
`ifndef TWM_CFG_SVH
`define TWM_CFG_SVH
`define OFF_DATA 12'h000
`define OFF_STATUS 12'h004
`define OFF_CONTROL 12'h008
`define OFF_IRQ_STAT 12'h00c
`define OFF_IRQ_MASK 12'h010
`define OFF_DIV 12'h014
`define CTL_STEP_DONE 7
`define CTL_ACK_EN 6
`define CTL_START 5
`define CTL_STOP 4
`define CTL_ENABLE 2
`define ST_START 8'h08
`define ST_RSTART 8'h10
`define ST_MT_ADDR_ACK 8'h18
`define ST_MT_ADDR_NACK 8'h20
`define ST_ARB_LOST 8'h38
`define ST_ADDR_ACK 8'h40
`define ST_ADDR_NACK 8'h48
`define ST_DATA_ACK 8'h50
`define ST_DATA_NACK 8'h58
`define ST_IDLE 8'hf8
`define DIV_RESET 16'h0032
`endif

// ### twm_pkg.sv
// Types used by the two-wire master receiver sequencer file
package twm_pkg;
   typedef struct packed
   {
      logic step_done;
      logic ack_enable;
      logic start_req;
      logic stop_req;
      logic enable;
   } ctl_t;
   typedef enum logic [7:0]
   {
      S_IDLE = 8'h01,
      S_START = 8'h02,
      S_WAIT_SW = 8'h04,
      S_BYTE = 8'h08,
      S_ACK = 8'h10,
      S_STOP = 8'h20,
      S_WAIT_FREE = 8'h40,
      S_RSTART = 8'h80
   } state_t;
endpackage

// ### twm_shift.sv
// Eight-bit shifter of the bus byte; software reads the shift store itself
module twm_shift
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic load,
   input wire logic [7:0] load_val,
   input wire logic shift,
   input wire logic in_bit,
   output logic [7:0] q
);
   // One store: loaded by software, shifted on each sampled bus bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= 8'h00;
      else if (ce && load)
         q <= load_val;
      else if (ce && shift)
         q <= {q[6:0], in_bit};
   end
endmodule // twm_shift

// ### twm_master_rx.sv
// Two-wire master receiver sequencer with an APB register file
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`include "twm_cfg.svh"
module twm_master_rx
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic irq
);
   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: second stage is the only reader of the first
   logic scl_m_r, scl_s_r, sda_m_r, sda_s_r, scl_d_r, sda_d_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else if (ce)
      begin
         scl_m_r <= scl_in;
         scl_s_r <= scl_m_r;
         sda_m_r <= sda_in;
         sda_s_r <= sda_m_r;
         scl_d_r <= scl_s_r;
         sda_d_r <= sda_s_r;
      end
   end

   // Bus free/busy tracking from start and stop seen on the wires
   wire start_seen = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
   wire stop_seen = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
   wire scl_rise = scl_s_r && !scl_d_r;
   logic busy_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         busy_r <= 1'b0;
      else if (ce && start_seen)
         busy_r <= 1'b1;
      else if (ce && stop_seen)
         busy_r <= 1'b0;
   end

   //////////////////////////////////////////////////////////////////////////
   // Registers
   twm_pkg::ctl_t ctl_r;
   twm_pkg::state_t st_r, st_nxt;
   logic [7:0] status_r, status_nxt;
   logic [7:0] irq_stat_r, irq_mask_r;
   logic [15:0] div_r, cnt_r;
   logic [1:0] ph_r;
   logic [3:0] bit_r;
   logic rx_mode_r, lost_r, ack_bit_r, restart_after_stop_r;
   logic [7:0] shreg;

   // APB decode
   wire acc = psel && penable && ce;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire hit_data = paddr == `OFF_DATA;
   wire hit_stat = paddr == `OFF_STATUS;
   wire hit_ctl = paddr == `OFF_CONTROL;
   wire hit_istat = paddr == `OFF_IRQ_STAT;
   wire hit_imask = paddr == `OFF_IRQ_MASK;
   wire hit_div = paddr == `OFF_DIV;
   wire mapped = hit_data | hit_stat | hit_ctl | hit_istat | hit_imask | hit_div;
   wire ctl_wr = wr && hit_ctl;
   wire flag_clear = ctl_wr && pwdata[`CTL_STEP_DONE];
   wire [31:0] ctl_word = {24'h000000, ctl_r.step_done, ctl_r.ack_enable, ctl_r.start_req,
      ctl_r.stop_req, 1'b0, ctl_r.enable, 2'b00};
   wire [31:0] rd_mux = hit_data ? {24'h000000, shreg} :
      hit_stat ? {24'h000000, status_r[7:3], 3'b000} :
      hit_ctl ? ctl_word :
      hit_istat ? {24'h000000, irq_stat_r} :
      hit_imask ? {24'h000000, irq_mask_r} :
      hit_div ? {16'h0000, div_r} : 32'h00000000;

   // Bus slave answers in the access cycle; unmapped addresses give an error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end
      else if (ce)
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= (psel && !penable && !pwrite) ? rd_mux : prdata;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Bit timing: quarter-period ticks while the bus clock may run
   wire stalled = ctl_r.step_done || st_r == twm_pkg::S_IDLE || st_r == twm_pkg::S_WAIT_SW;
   wire tick = (cnt_r == 16'h0000) && !stalled;
   // Clock stretching: a slave holding the clock low stops the phase counter
   wire stretch = ph_r == 2'd2 && !scl_s_r && scl_out;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_r <= `DIV_RESET;
      else if (ce)
         cnt_r <= (cnt_r == 16'h0000 || stalled) ? div_r : (stretch ? cnt_r : cnt_r - 16'h0001);
   end

   // Bit sequencer
   wire last_bit = bit_r == 4'd7;
   wire addr_read = shreg[0];
   wire arb_lose = tick && ph_r == 2'd2 && sda_out && !sda_s_r && st_r == twm_pkg::S_BYTE && !rx_mode_r;
   always_comb
   begin
      st_nxt = st_r;
      status_nxt = status_r;
      unique case (st_r)
         twm_pkg::S_IDLE:
            if (ctl_r.enable && ctl_r.start_req && !ctl_r.step_done)
               st_nxt = busy_r ? twm_pkg::S_WAIT_FREE : twm_pkg::S_START;
         twm_pkg::S_WAIT_FREE:
            if (!busy_r)
               st_nxt = twm_pkg::S_START;
         twm_pkg::S_START, twm_pkg::S_RSTART:
            if (tick && ph_r == 2'd3)
            begin
               st_nxt = twm_pkg::S_WAIT_SW;
               status_nxt = st_r == twm_pkg::S_START ? `ST_START : `ST_RSTART;
            end
         twm_pkg::S_BYTE:
            if (arb_lose)
            begin
               st_nxt = twm_pkg::S_WAIT_SW;
               status_nxt = `ST_ARB_LOST;
            end
            else if (tick && ph_r == 2'd3 && last_bit)
               st_nxt = twm_pkg::S_ACK;
         twm_pkg::S_ACK:
            if (tick && ph_r == 2'd3)
            begin
               st_nxt = twm_pkg::S_WAIT_SW;
               if (!rx_mode_r)
               begin
                  if (addr_read)
                     status_nxt = ack_bit_r ? `ST_ADDR_NACK : `ST_ADDR_ACK;
                  else
                     status_nxt = ack_bit_r ? `ST_MT_ADDR_NACK : `ST_MT_ADDR_ACK;
               end
               else
                  status_nxt = ack_bit_r ? `ST_DATA_NACK : `ST_DATA_ACK;
            end
         twm_pkg::S_STOP:
            if (tick && ph_r == 2'd3)
            begin
               st_nxt = restart_after_stop_r ? twm_pkg::S_WAIT_FREE : twm_pkg::S_IDLE;
               status_nxt = `ST_IDLE;
            end
         twm_pkg::S_WAIT_SW:
            if (!ctl_r.step_done)
            begin
               if (status_r == `ST_ARB_LOST)
                  st_nxt = ctl_r.start_req ? twm_pkg::S_WAIT_FREE : twm_pkg::S_IDLE;
               else if (ctl_r.stop_req)
                  st_nxt = twm_pkg::S_STOP;
               else if (ctl_r.start_req)
                  st_nxt = twm_pkg::S_RSTART;
               else
                  st_nxt = twm_pkg::S_BYTE;
               if (st_nxt != twm_pkg::S_WAIT_SW)
                  status_nxt = `ST_IDLE;
            end
         default:
            st_nxt = twm_pkg::S_IDLE;
      endcase
   end

   // State follows the sequencer; phase and bit counters advance on ticks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= twm_pkg::S_IDLE;
         status_r <= `ST_IDLE;
         ph_r <= 2'd0;
         bit_r <= 4'd0;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
         status_r <= status_nxt;
         ph_r <= (st_nxt != st_r) ? 2'd0 : (tick && !stretch ? ph_r + 2'd1 : ph_r);
         bit_r <= (st_r == twm_pkg::S_BYTE && tick && ph_r == 2'd3) ? bit_r + 4'd1 :
            (st_r != twm_pkg::S_BYTE ? 4'd0 : bit_r);
      end
   end

   // Direction, acknowledge and restart bookkeeping
   wire addr_phase_end = st_r == twm_pkg::S_ACK && st_nxt == twm_pkg::S_WAIT_SW && !rx_mode_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_mode_r <= 1'b0;
         ack_bit_r <= 1'b1;
         lost_r <= 1'b0;
         restart_after_stop_r <= 1'b0;
      end
      else if (ce)
      begin
         if (st_r == twm_pkg::S_START || st_r == twm_pkg::S_RSTART)
            rx_mode_r <= 1'b0;
         else if (addr_phase_end && addr_read && !ack_bit_r)
            rx_mode_r <= 1'b1;
         if (st_r == twm_pkg::S_ACK && tick && ph_r == 2'd2)
            ack_bit_r <= sda_s_r;
         lost_r <= arb_lose;
         if (st_r == twm_pkg::S_WAIT_SW && st_nxt == twm_pkg::S_STOP)
            restart_after_stop_r <= ctl_r.start_req;
         else if (st_r == twm_pkg::S_STOP && st_nxt != twm_pkg::S_STOP)
            restart_after_stop_r <= 1'b0;
      end
   end

   // Data byte: software load or bus shift
   // Receive samples in the middle of the high phase; transmit moves on only at the bit's end,
   // so the data line never changes while the clock is high
   twm_shift u_shift
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .load(wr && hit_data && st_r == twm_pkg::S_WAIT_SW),
      .load_val(pwdata[7:0]),
      .shift(st_r == twm_pkg::S_BYTE && tick && ph_r == (rx_mode_r ? 2'd2 : 2'd3) && !stretch),
      .in_bit(rx_mode_r ? sda_s_r : shreg[7]),
      .q(shreg)
   );

   //////////////////////////////////////////////////////////////////////////
   // Control register; hardware set of the step flag wins over a clear
   wire step_set = st_r != twm_pkg::S_WAIT_SW && st_nxt == twm_pkg::S_WAIT_SW;
   wire stop_done = st_r == twm_pkg::S_STOP && st_nxt != twm_pkg::S_STOP;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctl_r <= '0;
      else if (ce)
      begin
         if (ctl_wr)
         begin
            ctl_r.ack_enable <= pwdata[`CTL_ACK_EN];
            ctl_r.start_req <= pwdata[`CTL_START];
            ctl_r.enable <= pwdata[`CTL_ENABLE];
         end
         if (stop_done)
            ctl_r.stop_req <= 1'b0;
         else if (ctl_wr)
            ctl_r.stop_req <= pwdata[`CTL_STOP];
         if (step_set)
            ctl_r.step_done <= 1'b1;
         else if (flag_clear)
            ctl_r.step_done <= 1'b0;
         if (st_r == twm_pkg::S_START && !ctl_wr)
            ctl_r.start_req <= 1'b0;
      end
   end

   // Interrupt status: bit0 step done, bit1 arbitration lost, bit2 stop sent
   wire istat_rd = rd && hit_istat;
   wire [7:0] ev = {5'b00000, stop_done, lost_r, step_set};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_r <= 8'h00;
         irq_mask_r <= 8'h00;
         div_r <= `DIV_RESET;
         irq <= 1'b0;
      end
      else if (ce)
      begin
         irq_stat_r <= (istat_rd ? 8'h00 : irq_stat_r) | ev;
         if (wr && hit_imask)
            irq_mask_r <= pwdata[7:0];
         if (wr && hit_div)
            div_r <= pwdata[15:0];
         irq <= |(((istat_rd ? 8'h00 : irq_stat_r) | ev) & irq_mask_r);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Pin drive: open drain, enable high while pulling low
   logic scl_lo, sda_lo;
   always_comb
   begin
      scl_lo = 1'b0;
      sda_lo = 1'b0;
      unique case (st_r)
         twm_pkg::S_START:
         begin
            sda_lo = ph_r >= 2'd1;
            scl_lo = ph_r == 2'd3;
         end
         twm_pkg::S_RSTART:
         begin
            scl_lo = ph_r == 2'd0;
            sda_lo = ph_r >= 2'd2;
         end
         twm_pkg::S_BYTE:
         begin
            scl_lo = ph_r < 2'd2;
            sda_lo = !rx_mode_r && !shreg[7];
         end
         twm_pkg::S_ACK:
         begin
            scl_lo = ph_r < 2'd2;
            sda_lo = rx_mode_r && ctl_r.ack_enable;
         end
         twm_pkg::S_STOP:
         begin
            scl_lo = ph_r == 2'd0;
            sda_lo = ph_r < 2'd3;
         end
         twm_pkg::S_WAIT_SW:
            scl_lo = status_r != `ST_ARB_LOST;
         default:
         begin
            scl_lo = 1'b0;
            sda_lo = 1'b0;
         end
      endcase
   end

   // Data drive lags the clock drive by one cycle: hold time after every clock fall
   logic sda_lo_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_out <= 1'b1;
         sda_out <= 1'b1;
         sda_lo_r <= 1'b0;
      end
      else if (ce)
      begin
         scl_oe <= scl_lo;
         sda_lo_r <= sda_lo;
         sda_oe <= sda_lo_r;
         scl_out <= !scl_lo;
         sda_out <= !sda_lo_r;
      end
   end
endmodule // twm_master_rx

// ### twm_master_rx_sva.sv
// Port-level assertions for the two-wire master receiver
module twm_master_rx_sva
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   //////////////////////////////////////////
   // Access decode; places past the divider are not mapped
   wire setup = psel && !penable;
   wire unmapped = paddr > 12'h014;
   //////////////////////////////////////////
   a_ready_next: assert property (setup |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_unmapped_err: assert property (setup && unmapped |=> pslverr)
      else $error("unmapped access not refused");
   a_unmapped_zero: assert property (setup && unmapped && !pwrite |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_mapped_ok: assert property (setup && !unmapped && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped access refused");
   a_status_pad: assert property (setup && !pwrite && paddr == 12'h004 |=> prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0)
      else $error("status pad bits set");
   a_reset_free: assert property ($rose(presetn) |-> !scl_oe && !sda_oe)
      else $error("bus driven after reset");
   // Main scenarios
   c_status: cover property (setup && !pwrite && paddr == 12'h004);
   c_refused: cover property (pslverr);
   c_irq: cover property ($rose(irq));
   c_start: cover property ($rose(sda_oe) && !scl_oe);
endmodule // twm_master_rx_sva

bind twm_master_rx twm_master_rx_sva chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

// ### twm_slave_model.sv
// Behavioural bus slave that answers reads with a fixed byte pair
module twm_slave_model
#(
   parameter logic [6:0] ADDR = 7'h50
)
(
   input wire logic scl,
   input wire logic sda,
   output logic pull
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] tx [2] = '{8'ha5, 8'h3c};
   logic stopped;
   //////////////////////////////////////////
   // One addressed transfer; releasing lets the pull-up win, so no stale bit shows
   task automatic xfer();
      logic [7:0] b;
      logic more;
      int k;
      k = 0;
      b = 8'h00;
      repeat (8)
      begin
         @(posedge scl);
         b = {b[6:0], sda};
      end
      @(negedge scl);
      if (b[7:1] == ADDR)
         pull = 1'b1;
      @(negedge scl);
      more = b[0] && b[7:1] == ADDR;
      if (!more)
         pull = 1'b0;
      // Bytes change only while the clock is low
      while (more)
      begin
         for (int i = 7; i >= 0; i--)
         begin
            pull = !tx[k][i];
            @(negedge scl);
         end
         pull = 1'b0;
         @(posedge scl);
         more = !sda;
         k = 1 - k;
         // Next byte is driven only after the clock falls again
         @(negedge scl);
      end
      forever @(posedge scl);
   endtask
   //////////////////////////////////////////
   // A start or stop on the wire aborts whatever byte is in flight
   initial
   begin
      pull = 1'b0;
      forever
      begin
         @(negedge sda iff scl === 1'b1);
         stopped = 1'b0;
         while (!stopped)
         begin
            fork
               begin
                  @(posedge sda iff scl === 1'b1);
                  stopped = 1'b1;
               end
               @(negedge sda iff scl === 1'b1);
               xfer();
            join_any
            disable fork;
            pull = 1'b0;
         end
      end
   end
endmodule // twm_slave_model

// ### tb.sv
// Self-checking bench for the two-wire master receiver
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] EN = 32'h04, STEP = 32'h80, ACK = 32'h40, START_RQ = 32'h20, STOP_RQ = 32'h10;
   logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, pull, err, im = 1'b0;
   logic scl_w, sda_w;
   int fails = 0, total_checks = 0, cyc = 0, stops = 0, n0;
   //////////////////////////////////////////
   // Clock, open-drain wires with pull-ups, stop counter
   always #2 pclk = ~pclk;
   assign scl_w = ~scl_oe;
   assign sda_w = ~(sda_oe | pull);
   always @(posedge sda_w)
      if (scl_w === 1'b1)
         stops++;
   twm_master_rx DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .irq(irq));
   twm_slave_model #(.ADDR(7'h50)) peer (.scl(scl_w), .sda(sda_w), .pull(pull));
   //////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // One APB transfer; an idle cycle follows so no signal is driven twice at one edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 20)
         chk(32'h0, 32'h1, "apb hang");
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask
   task automatic poll(input int b, input logic v);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, 12'h008, 32'h0);
         n++;
      end
      while (rd[b] !== v && n < 400);
   endtask
   // Answer a code, wait for the next one, then clear and check it
   task automatic step(input logic [31:0] ctl, input logic [7:0] code);
      apb(1'b1, 12'h008, ctl);
      poll(7, 1'b1);
      chk({31'h0, irq}, {31'h0, im}, "irq level");
      apb(1'b0, 12'h00c, 32'h0);
      chk({31'h0, rd[0]}, 32'h1, "step event");
      rchk(12'h004, {24'h0, code}, "status");
      chk({31'h0, irq}, 32'h0, "irq cleared");
   endtask
   //////////////////////////////////////////
   // Hang guard; the tests need about a thousand cycles
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         fails++;
         $display("[FAIL] %0t timeout", $time);
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(12'h004, 32'hf8, "idle status");
      rchk(12'h014, 32'h32, "divider reset");
      rchk(12'h008, 32'h0, "control reset");
      rchk(12'h010, 32'h0, "mask reset");
      rchk(12'h040, 32'h0, "unmapped read");
      chk({31'h0, err}, 32'h1, "unmapped error");
      $display("test reset done");
      apb(1'b1, 12'h014, 32'h2);
      apb(1'b1, 12'h010, 32'h1);
      im = 1'b1;
      step(EN | START_RQ, 8'h08);
      apb(1'b1, 12'h000, 32'ha1);
      step(STEP | EN, 8'h40);
      step(STEP | EN | ACK, 8'h50);
      rchk(12'h000, 32'ha5, "first byte");
      step(STEP | EN, 8'h58);
      rchk(12'h000, 32'h3c, "last byte");
      n0 = stops;
      apb(1'b1, 12'h008, STEP | EN | STOP_RQ);
      poll(4, 1'b0);
      chk({31'h0, rd[4]}, 32'h0, "stop bit");
      chk(stops - n0, 32'h1, "stop count");
      chk({30'h0, scl_w, sda_w}, 32'h3, "bus free");
      chk({30'h0, scl_out, sda_out}, 32'h3, "pins released");
      $display("test read done");
      step(EN | START_RQ, 8'h08);
      apb(1'b1, 12'h000, 32'h11);
      step(STEP | EN | ACK, 8'h48);
      step(STEP | EN | START_RQ, 8'h10);
      apb(1'b1, 12'h000, 32'h11);
      step(STEP | EN, 8'h48);
      n0 = stops;
      step(STEP | EN | START_RQ | STOP_RQ, 8'h08);
      chk(stops - n0, 32'h1, "stop before start");
      rchk(12'h008, STEP | EN, "requests cleared");
      apb(1'b1, 12'h000, 32'h11);
      step(STEP | EN, 8'h48);
      step(STEP | EN | START_RQ, 8'h10);
      apb(1'b1, 12'h010, 32'h0);
      im = 1'b0;
      apb(1'b1, 12'h000, 32'ha0);
      step(STEP | EN, 8'h18);
      $display("test restart done");
      tally_and_finish();
   end
endmodule // tb
